// ---- mode_map.vh ----
// Purpose: constants for the converter mode word decoder
// Assumes: 16-bit serial frames, msb first, sampled on the frame clock falling edge
// Notes:   field positions, codes and reset values
`ifndef MODE_MAP_VH
`define MODE_MAP_VH
`define FRAME_BITS        16
`define WORD_SELECT_BIT   15
`define SCAN_HI           14
`define SCAN_LO           11
`define CHAN_HI           10
`define CHAN_LO           7
`define RESET_HI          6
`define RESET_LO          5
`define POWER_HI          4
`define POWER_LO          3
`define CHANNEL_TAG_BIT   2
`define SOFT_TRIGGER_BIT  1
`define SCAN_HOLD         4'h0
`define SCAN_MANUAL       4'h1
`define SCAN_REPEAT       4'h2
`define SCAN_STANDARD_INT 4'h3
`define SCAN_RESET_VAL    4'h1
`define CHAN_RESET_VAL    4'h0
`define POWER_RESET_VAL   2'h0
`define RESET_NONE        2'h0
`define RESET_FIFO        2'h1
`define RESET_ALL         2'h2
`define REPEAT_LAST       5'h0F
`endif

// ---- sync_edge.v ----
// Purpose: two-flop synchroniser with rise and fall pulses
// Assumes: input is asynchronous to clk
// Notes:   first flop feeds only the second
`timescale 1ns/1ps
module sync_edge #(
  parameter [0:0] RESET_LEVEL = 1'b0
) (
  input  wire clk,
  input  wire reset_n,
  input  wire asyncIn,
  output reg  level,
  output wire rise,
  output wire fall
);
  reg meta;
  reg levelDly;
  // two flops, then a delayed copy for edge detection; all reset to the pin's
  // idle level so that no false edge appears right after reset
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta     <= RESET_LEVEL;
      level    <= RESET_LEVEL;
      levelDly <= RESET_LEVEL;
    end else begin
      meta     <= asyncIn;
      level    <= meta;
      levelDly <= level;
    end
  end
  assign rise = level & ~levelDly;
  assign fall = ~level & levelDly;
endmodule // sync_edge

// ---- mode_word_ctrl.v ----
// Purpose: serial receiver and decoder for the converter mode control word
// Assumes: host drives frameClk, chipSelect_n and serialIn; all sampled on clk
// Notes:   result shift-out uses conversion data from the converter core
`timescale 1ns/1ps
`include "mode_map.vh"

module mode_word_ctrl (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        frameClk,
  input  wire        chipSelect_n,
  input  wire        serialIn,
  input  wire        convertStartPin,
  input  wire [11:0] resultData,
  input  wire [3:0]  resultChannel,
  output reg         serialOut,
  output reg  [3:0]  scanMode,
  output reg  [3:0]  channelNumberSelect,
  output reg  [1:0]  powerModeSelect,
  output reg         channelTagEnable,
  output reg         internalClockMode,
  output reg         averageAllowed,
  output reg         fifoStore,
  output reg         fifoReset,
  output reg         convertStart,
  output reg  [3:0]  convertChannel,
  output reg         powerDown
);
  wire sclkRise, sclkFall;
  wire csLevel, csRise, csFall;
  wire dinLevel, cnvRise;

  // frame clock idles low; only its edges are used
  sync_edge #(
    .RESET_LEVEL (1'b0)
  ) uSclk (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (frameClk),
    .level   (),
    .rise    (sclkRise),
    .fall    (sclkFall)
  );
  // chip select idles high, so its flops reset high and no edge follows reset
  sync_edge #(
    .RESET_LEVEL (1'b1)
  ) uCs (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (chipSelect_n),
    .level   (csLevel),
    .rise    (csRise),
    .fall    (csFall)
  );
  // serial data is read as a level at the frame clock falling edge
  sync_edge #(
    .RESET_LEVEL (1'b0)
  ) uDin (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (serialIn),
    .level   (dinLevel),
    .rise    (),
    .fall    ()
  );
  // convert start pin: only its rising edge matters
  sync_edge #(
    .RESET_LEVEL (1'b0)
  ) uCnv (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (convertStartPin),
    .level   (),
    .rise    (cnvRise),
    .fall    ()
  );

  reg  [15:0] shiftIn_reg;
  reg  [4:0]  bitCount_reg;
  reg  [15:0] shiftOut_reg;
  reg         softTrigger_reg;

  // frame complete when chip select rises after 16 or more bits; bits past the 16th are not shifted in
  wire        frameDone = csRise & (bitCount_reg == 5'h10);
  wire [15:0] word      = shiftIn_reg;
  wire        modeWrite = frameDone & ~word[`WORD_SELECT_BIT];
  wire [3:0]  newScan   = word[`SCAN_HI:`SCAN_LO];
  wire        scanHold  = (newScan == `SCAN_HOLD);
  wire [1:0]  resetCode = word[`RESET_HI:`RESET_LO];
  // internal clock modes are repeat and standard; manual is external only
  wire        newIntClk = (newScan == `SCAN_REPEAT) | (newScan == `SCAN_STANDARD_INT);

  // serial input capture, counting bits of the frame
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftIn_reg  <= 16'h0000;
      bitCount_reg <= 5'h00;
    end else if (csFall) begin
      bitCount_reg <= 5'h00;
    end else if (!csLevel && sclkFall && bitCount_reg != 5'h10) begin
      // host changes data on rising edge, so sample on falling
      shiftIn_reg  <= {shiftIn_reg[14:0], dinLevel};
      bitCount_reg <= bitCount_reg + 5'h01;
    end
  end

  // mode word fields; bit 0 is never looked at
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scanMode            <= `SCAN_RESET_VAL;
      channelNumberSelect <= `CHAN_RESET_VAL;
      powerModeSelect     <= `POWER_RESET_VAL;
      channelTagEnable    <= 1'b0;
      internalClockMode   <= 1'b0;
      averageAllowed      <= 1'b0;
      softTrigger_reg     <= 1'b0;
      fifoReset           <= 1'b0;
    end else begin
      fifoReset <= 1'b0;
      if (modeWrite && resetCode == `RESET_ALL) begin
        scanMode            <= `SCAN_RESET_VAL;
        channelNumberSelect <= `CHAN_RESET_VAL;
        powerModeSelect     <= `POWER_RESET_VAL;
        channelTagEnable    <= 1'b0;
        internalClockMode   <= 1'b0;
        averageAllowed      <= 1'b0;
        softTrigger_reg     <= 1'b0;
        fifoReset           <= 1'b1;
      end else if (modeWrite) begin
        fifoReset        <= (resetCode == `RESET_FIFO);
        powerModeSelect  <= word[`POWER_HI:`POWER_LO];
        channelTagEnable <= word[`CHANNEL_TAG_BIT];
        softTrigger_reg  <= word[`SOFT_TRIGGER_BIT];
        if (!scanHold) begin
          scanMode            <= newScan;
          channelNumberSelect <= word[`CHAN_HI:`CHAN_LO];
          internalClockMode   <= newIntClk;
          averageAllowed      <= newIntClk;
        end
      end else if (softTrigger_reg && csRise) begin
        // one write buys one software-triggered scan
        softTrigger_reg <= 1'b0;
      end
    end
  end

  // power-down follows the power field only while the external clock is in use
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      powerDown <= 1'b0;
    else
      powerDown <= ~internalClockMode & (powerModeSelect != `POWER_RESET_VAL);
  end

  // conversion sequencing
  reg [3:0] scanChan_reg;
  reg [4:0] repeatCount_reg;
  reg       scanBusy_reg;
  wire      intStart = internalClockMode & ((softTrigger_reg & csRise) |
                                            (~softTrigger_reg & cnvRise));
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      convertStart    <= 1'b0;
      convertChannel  <= 4'h0;
      fifoStore       <= 1'b0;
      scanChan_reg    <= 4'h0;
      repeatCount_reg <= 5'h00;
      scanBusy_reg    <= 1'b0;
    end else begin
      convertStart <= 1'b0;
      fifoStore    <= 1'b0;
      if (modeWrite && !scanHold && newScan == `SCAN_MANUAL) begin
        // manual: convert the channel named in this frame now
        convertStart    <= 1'b1;
        convertChannel  <= word[`CHAN_HI:`CHAN_LO];
        scanBusy_reg    <= 1'b0;
      end else if (modeWrite && (!scanHold || resetCode == `RESET_ALL)) begin
        // a new setup or a full reset drops any scan in flight, so a half-done
        // sequence never runs on against a new channel number or scan code
        scanBusy_reg <= 1'b0;
      end else if (intStart && !scanBusy_reg) begin
        scanBusy_reg    <= 1'b1;
        scanChan_reg    <= (scanMode == `SCAN_STANDARD_INT) ? 4'h0 : channelNumberSelect;
        repeatCount_reg <= 5'h00;
      end else if (scanBusy_reg) begin
        // one conversion per clock; core handles actual pacing
        convertStart   <= 1'b1;
        convertChannel <= scanChan_reg;
        fifoStore      <= 1'b1;
        if (scanMode == `SCAN_REPEAT) begin
          repeatCount_reg <= repeatCount_reg + 5'h01;
          if (repeatCount_reg == `REPEAT_LAST)
            scanBusy_reg <= 1'b0;
        end else if (scanChan_reg == channelNumberSelect) begin
          scanBusy_reg <= 1'b0;
        end else begin
          scanChan_reg <= scanChan_reg + 4'h1;
        end
      end
    end
  end

  // output word: load at frame start, shift on rising frame clock
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftOut_reg <= 16'h0000;
      serialOut    <= 1'b0;
    end else if (csFall) begin
      if (internalClockMode || channelTagEnable)
        shiftOut_reg <= {resultChannel, resultData};
      else
        shiftOut_reg <= {resultData, 4'h0};
      serialOut <= 1'b0;
    end else if (!csLevel && sclkRise) begin
      serialOut    <= shiftOut_reg[15];
      shiftOut_reg <= {shiftOut_reg[14:0], 1'b0};
    end
  end
endmodule // mode_word_ctrl

// ---- mode_word_ctrl_sva.sv ----
// Purpose: assertions on the mode word decoder outputs
// Assumes: sees only the ports of mode_word_ctrl
// Notes:   scan order and pulse pairing tied to the decoded fields
`timescale 1ns/1ps
module mode_word_ctrl_sva (
  input wire       clk,
  input wire       reset_n,
  input wire [3:0] scanMode,
  input wire [3:0] channelNumberSelect,
  input wire [1:0] powerModeSelect,
  input wire       internalClockMode,
  input wire       averageAllowed,
  input wire       fifoStore,
  input wire       fifoReset,
  input wire       convertStart,
  input wire [3:0] convertChannel,
  input wire       powerDown
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // settled fields only: powerDown may trail the field by a cycle
  a_power_down: assert property ($stable(powerModeSelect) && $stable(internalClockMode)
    |-> powerDown == (!internalClockMode && powerModeSelect != 2'h0)) else $error("power down level wrong");
  a_clock_mode: assert property (internalClockMode == (scanMode == 4'h2 || scanMode == 4'h3))
    else $error("clock mode not from scan code");
  a_average_mode: assert property (averageAllowed == internalClockMode) else $error("averaging mismatch");
  a_scan_kept: assert property (scanMode != 4'h0) else $error("hold code became a scan mode");
  a_reset_pulse: assert property (fifoReset |=> !fifoReset) else $error("fifo reset longer than one cycle");
  a_store_pair: assert property (convertStart && internalClockMode |-> fifoStore) else $error("result not stored");
  a_chan_source: assert property (convertStart && scanMode != 4'h3 |-> convertChannel == channelNumberSelect)
    else $error("convert channel not the selected one");
  a_scan_start: assert property (convertStart && !$past(convertStart) && scanMode == 4'h3 |-> convertChannel == 4'h0)
    else $error("standard scan not from channel zero");
  a_scan_step: assert property (scanMode == 4'h3 && convertStart && convertChannel != channelNumberSelect
    |=> convertStart && convertChannel == $past(convertChannel) + 4'h1) else $error("scan not ascending");
  a_scan_end: assert property (scanMode == 4'h3 && convertStart && convertChannel == channelNumberSelect
    |=> !convertStart) else $error("scan ran past last channel");
endmodule // mode_word_ctrl_sva

// ---- frame_host.sv ----
// Purpose: host model sending 16-bit frames
// Assumes: frame clock period 125 ns, idle low between frames
// Notes:   data changes on rising frame clock, reply taken on falling
`timescale 1ns/1ps
module frame_host (
  output reg  frameClk,
  output reg  chipSelect_n,
  output reg  serialIn,
  input  wire serialOut
);
  reg [15:0] reply;
  initial begin
    frameClk = 1'b0;
    chipSelect_n = 1'b1;
    serialIn = 1'b0;
    reply = 16'h0000;
  end
  // whole frame msb first; caller clears bit 15 for the mode word
  task send(input [15:0] word);
    integer i;
    begin
      chipSelect_n = 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        #62.5 frameClk = 1'b1;
        serialIn = word[i];
        #62.5 frameClk = 1'b0;
        reply[i] = serialOut;
      end
      #62.5 chipSelect_n = 1'b1;
      serialIn = ~serialIn; // released line never shows the last bit
      #500;
    end
  endtask
endmodule // frame_host

// ---- testbench.sv ----
// Purpose: self-checking bench for the mode word decoder
// Assumes: host model frames at 125 ns, clk at 8 ns
// Notes:   pulses are counted; fields checked once a frame has settled
`timescale 1ns/1ps
module testbench;
  reg         clk;
  reg         reset_n;
  reg  [11:0] resultData;
  reg  [3:0]  resultChannel;
  wire        frameClk, chipSelect_n, serialIn, serialOut, channelTagEnable, internalClockMode;
  wire        averageAllowed, fifoStore, fifoReset, convertStart, powerDown;
  wire [3:0]  scanMode, channelNumberSelect, convertChannel;
  wire [1:0]  powerModeSelect;
  reg         convertStartPin;
  integer     miscompares, comparisons, cycles;
  reg  [15:0] starts, stores, resets, s0, f0, r0;
  frame_host u_host (.frameClk(frameClk), .chipSelect_n(chipSelect_n), .serialIn(serialIn), .serialOut(serialOut));
  mode_word_ctrl u_mode_word_ctrl (.clk(clk), .reset_n(reset_n), .frameClk(frameClk), .chipSelect_n(chipSelect_n),
    .serialIn(serialIn), .convertStartPin(convertStartPin), .resultData(resultData), .resultChannel(resultChannel),
    .serialOut(serialOut), .scanMode(scanMode), .channelNumberSelect(channelNumberSelect),
    .powerModeSelect(powerModeSelect), .channelTagEnable(channelTagEnable), .internalClockMode(internalClockMode),
    .averageAllowed(averageAllowed), .fifoStore(fifoStore), .fifoReset(fifoReset), .convertStart(convertStart),
    .convertChannel(convertChannel), .powerDown(powerDown));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // pulse counters and hang limit
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (convertStart === 1'b1) starts = starts + 16'h0001;
    if (fifoStore === 1'b1) stores = stores + 16'h0001;
    if (fifoReset === 1'b1) resets = resets + 16'h0001;
    if (cycles == 12000) begin
      miscompares = miscompares + 1;
      finish_test;
    end
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task frame(input [15:0] w);
    begin
      s0 = starts;
      f0 = stores;
      r0 = resets;
      u_host.send(w);
    end
  endtask
  // one pulse on the convert start pin, then time for a whole scan
  task pulse_pin;
    begin
      s0 = starts;
      f0 = stores;
      @(posedge clk);
      #1 convertStartPin = 1'b1;
      repeat (4) @(posedge clk);
      #1 convertStartPin = 1'b0;
      repeat (40) @(posedge clk);
    end
  endtask
  task t_reset;
    begin
      check({8'h00, channelNumberSelect, powerModeSelect, channelTagEnable, internalClockMode}, 16'h0000);
      check({12'h000, scanMode}, 16'h0001);
      $display("reset values done");
    end
  endtask
  // manual, channel 5, power 2, tag on, bit 0 set
  task t_manual;
    begin
      frame(16'h0A95);
      check({scanMode, channelNumberSelect, 2'h0, powerModeSelect, 3'h0, powerDown}, 16'h1521);
      check({14'h0000, channelTagEnable, internalClockMode}, 16'h0002);
      check(starts - s0, 16'h0001);
      frame(16'h0A95);
      check(u_host.reply, 16'h5ABC);
      $display("manual done");
    end
  endtask
  // hold code still updates power and tag, keeps scan and channel
  task t_hold;
    begin
      frame(16'h0488);
      check({scanMode, channelNumberSelect, 2'h0, powerModeSelect, 3'h0, channelTagEnable}, 16'h1510);
      frame(16'h0000);
      check(u_host.reply, 16'hABC0);
      frame(16'hFFFF);
      check({scanMode, channelNumberSelect, 2'h0, powerModeSelect, 3'h0, channelTagEnable}, 16'h1500);
      check(resets - r0, 16'h0000);
      $display("hold and refuse done");
    end
  endtask
  // standard scan to 3 and repeat on 7, both by soft trigger
  task t_scan;
    begin
      frame(16'h198A);
      check({13'h0000, internalClockMode, averageAllowed, powerDown}, 16'h0006);
      check(starts - s0, 16'h0000);
      frame(16'h0000);
      check(starts - s0, 16'h0004);
      check(stores - f0, 16'h0004);
      check(u_host.reply, 16'h5ABC);
      frame(16'h0000);
      check(starts - s0, 16'h0000);
      frame(16'h1382);
      frame(16'h0000);
      check(starts - s0, 16'h0010);
      check(stores - f0, 16'h0010);
      pulse_pin;
      check(starts - s0, 16'h0010);
      $display("scan done");
    end
  endtask
  task t_resets;
    begin
      frame(16'h0020);
      check({12'h000, scanMode}, 16'h0002);
      check(resets - r0, 16'h0001);
      frame(16'h0040);
      check({8'h00, scanMode, channelNumberSelect}, 16'h0010);
      check(resets - r0, 16'h0001);
      pulse_pin;
      check(starts - s0, 16'h0000);
      $display("reset codes done");
    end
  endtask
  task finish_test;
    begin
      $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    miscompares = 0;
    comparisons = 0;
    cycles = 0;
    starts = 16'h0000;
    stores = 16'h0000;
    resets = 16'h0000;
    convertStartPin = 1'b0;
    reset_n = 1'b0;
    resultData = 12'hABC;
    resultChannel = 4'h5;
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_manual;
    t_hold;
    t_scan;
    t_resets;
    finish_test;
  end
endmodule // testbench
bind mode_word_ctrl mode_word_ctrl_sva u_mode_word_ctrl_sva (.clk, .reset_n, .scanMode, .channelNumberSelect,
  .powerModeSelect, .internalClockMode, .averageAllowed, .fifoStore, .fifoReset, .convertStart, .convertChannel,
  .powerDown);
